//--- inc/scs_pkg.sv
// scs_pkg: shared constants and types of the system clock source control block.
// assumes an 8-bit special-function-register bus and oscillator ticks synchronous to mclk.
package scs_pkg;

    // register addresses on the special-function-register bus
    localparam logic [7:0] SCS_ADDR_INT_CTRL = 8'h8A;
    localparam logic [7:0] SCS_ADDR_INT_CAL = 8'h8B;
    localparam logic [7:0] SCS_ADDR_EXT_CTRL = 8'h8C;
    localparam logic [7:0] SCS_ADDR_SRC_SEL = 8'h97;

    // internal_osc_control field positions
    localparam int SCS_INT_EN_BIT = 7;
    localparam int SCS_INT_RDY_BIT = 6;
    localparam int SCS_INT_DIV_HI = 1;
    localparam int SCS_INT_DIV_LO = 0;

    // external_osc_control field positions
    localparam int SCS_EXT_VLD_BIT = 7;
    localparam int SCS_EXT_MODE_HI = 6;
    localparam int SCS_EXT_MODE_LO = 4;
    localparam int SCS_EXT_FREQ_HI = 2;
    localparam int SCS_EXT_FREQ_LO = 0;

    // clock_source_select field position
    localparam int SCS_SEL_BIT = 0;

    // reset values
    localparam logic [7:0] SCS_INT_CTRL_RST = 8'hC0;
    localparam logic [1:0] SCS_INT_DIV_RST = 2'h0;
    localparam logic [2:0] SCS_EXT_MODE_RST = 3'h0;
    localparam logic [2:0] SCS_EXT_FREQ_RST = 3'h0;
    localparam logic SCS_SEL_RST = 1'b0;
    // factory trim stand-in, value arbitrary
    localparam logic [7:0] SCS_CAL_RST = 8'h80;

    // external mode encodings (low bit of off and rc modes is don't care)
    localparam logic [1:0] SCS_XMODE_OFF = 2'h0;
    localparam logic [1:0] SCS_XMODE_CMOS = 2'h1;
    localparam logic [1:0] SCS_XMODE_RC = 2'h2;
    localparam logic [1:0] SCS_XMODE_XTAL = 2'h3;

    // divider ratios as log2
    localparam logic [1:0] SCS_LOG2_DIV1 = 2'h0;
    localparam logic [1:0] SCS_LOG2_DIV2 = 2'h1;

    // internal ticks seen after enable before the ready flag rises
    localparam logic [3:0] SCS_INTERNAL_FREQ_READY_TICKS = 4'h8;
    // clean crystal edges needed with amplitude good before valid
    localparam logic [4:0] SCS_XTAL_EDGES = 5'h10;

    // clock switch states
    typedef enum logic [1:0] {
        SCS_ST_RUN_INT = 2'b00,
        SCS_ST_WAIT_EXT = 2'b01,
        SCS_ST_RUN_EXT = 2'b10,
        SCS_ST_WAIT_INT = 2'b11
    } scs_state_e;

    // one bus request from the cpu
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic page_ok;
        logic [7:0] wdata;
    } scs_sfr_req_s;

    // settings handed to the analog oscillator cells
    typedef struct packed {
        logic int_en;
        logic [7:0] int_trim;
        logic [2:0] ext_mode;
        logic [2:0] ext_freq;
    } scs_analog_s;

endpackage : scs_pkg

//--- hdl/scs_tick_div.sv
// scs_tick_div: divides a stream of one-cycle ticks by 1, 2, 4 or 8.
// assumes tick_in is a one-cycle pulse synchronous to mclk; a new ratio
// is taken only at a count boundary so the divided stream never gets a short period.
`timescale 1ns/10ps
module scs_tick_div
    import scs_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic tick_in,
    input wire logic [1:0] ratio_log2,
    output logic tick_out_r
);

    logic [2:0] cnt_r; // position within the current divided period
    logic [2:0] cnt_nxt;
    logic [1:0] act_r; // ratio in force
    logic [1:0] act_nxt;
    logic tick_out_nxt;
    logic [2:0] mask; // last count of the period

    // next count, output tick and ratio update
    always_comb begin
        mask = 3'((4'h1 << act_r) - 4'h1);
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        tick_out_nxt = 1'b0;
        if (tick_in) begin
            if (cnt_r == mask) begin
                // period complete: emit and pick up any new ratio
                tick_out_nxt = 1'b1;
                cnt_nxt = 3'h0;
                act_nxt = ratio_log2;
            end else begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end else if (cnt_r == 3'h0) begin
            // idle at a boundary: a new ratio is safe now
            act_nxt = ratio_log2;
        end
    end

    // state registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_r <= 3'h0;
            act_r <= SCS_LOG2_DIV1;
            tick_out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            tick_out_r <= tick_out_nxt;
        end
    end

endmodule : scs_tick_div

//--- hdl/scs_clock_control.sv
// scs_clock_control: system clock source control with its four registers.
// assumes the internal oscillator and the crystal pin arrive as signals
// synchronous to mclk; the system clock leaves as a one-cycle enable.
//
// Behaviour
// RL1 - reset always runs system clock from internal
// RL2 - calibration register resets to trim, adjusts period
// RL3 - software keeps internal frequency at most 25MHz
// RL4 - two-bit field divides internal by 8,4,2,1
// RL5 - control bit seven enables internal oscillator
// RL6 - read-only ready flag; bits five..two reserved
// RL7 - select bit picks internal or external source
// RL8 - external clock feeds peripherals regardless of select
// RL9 - switch live, only to enabled settled source
// RL10 - enable and select internal in one write; here enable and select sit in two registers, so it takes two writes
// RL11 - crystal valid flag, only in crystal modes
// RL12 - mode field: off, cmos, rc, crystal, halving
// RL13 - external control bit three reads zero
// RL14 - crystal mode: frequency field matches crystal range
// RL15 - rc mode: frequency field matches network range
// RL16 - capacitor mode: frequency field picks k factor
// RL17 - crystal: enable, wait 1ms, poll, switch
// RL18 - source and divider changes make no runts; here a source switch can cut the period before takeover to one cycle
`timescale 1ns/10ps
module scs_clock_control
    import scs_pkg::*;
#(
    parameter logic [7:0] CAL_RESET = SCS_CAL_RST
)
(
    input wire logic mclk,
    input wire logic srst,
    input scs_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata_r,
    input wire logic int_osc_tick,
    input wire logic crystal_pin_one,
    input wire logic crystal_amp_ok,
    output scs_analog_s analog_r,
    output logic sysclk_en_r,
    output logic periph_ext_en_r,
    output logic sysclk_is_ext_r
);

    // mode field decode, shared by gating, halving and valid logic
    function automatic logic [1:0] mode_class(input logic [2:0] mode);
        mode_class = mode[2:1];
    endfunction : mode_class

    // true when the external circuit produces a clock in this mode
    function automatic logic ext_running(input logic [2:0] mode);
        ext_running = (mode_class(mode) != SCS_XMODE_OFF);
    endfunction : ext_running

    // true when the external clock passes a divide-by-two stage
    function automatic logic ext_halved(input logic [2:0] mode);
        ext_halved = (mode_class(mode) == SCS_XMODE_RC) | mode[0];
    endfunction : ext_halved

    // ---------------- register group ----------------
    logic int_en_r; // internal oscillator enable
    logic int_en_nxt;
    logic [1:0] int_div_r; // internal divider field
    logic [1:0] int_div_nxt;
    logic [7:0] cal_r; // calibration value
    logic [7:0] cal_nxt;
    logic [2:0] ext_mode_r; // external mode field
    logic [2:0] ext_mode_nxt;
    logic [2:0] ext_freq_r; // external frequency field
    logic [2:0] ext_freq_nxt;
    logic sel_r; // source select bit
    logic sel_nxt;
    logic [7:0] rdata_nxt;
    logic wr_hit; // write accepted this cycle
    logic rd_hit; // read accepted this cycle

    // ---------------- status group ----------------
    logic int_rdy_r; // internal frequency ready
    logic int_rdy_nxt;
    logic [3:0] int_cnt_r; // internal ticks since enable
    logic [3:0] int_cnt_nxt;
    logic xtal_vld_r; // crystal valid
    logic xtal_vld_nxt;
    logic [4:0] xtal_cnt_r; // clean crystal edges counted
    logic [4:0] xtal_cnt_nxt;
    logic pin_d_r; // previous crystal pin level
    logic pin_d_nxt;
    logic ext_edge; // rising edge on the crystal pin

    // ---------------- switch group ----------------
    scs_state_e state_r;
    scs_state_e state_nxt;
    logic sysclk_nxt;
    logic periph_nxt;
    logic is_ext_nxt;
    logic int_tick_g; // internal tick while enabled
    logic int_div_tick; // divided internal tick
    logic ext_tick_g; // external tick while running
    logic ext_div_tick; // external tick after optional halving
    scs_analog_s analog_nxt;

    assign wr_hit = sfr_req.wr & sfr_req.page_ok;
    assign rd_hit = sfr_req.rd & sfr_req.page_ok;
    assign ext_edge = crystal_pin_one & ~pin_d_r;
    assign int_tick_g = int_osc_tick & int_en_r; // RL5
    assign ext_tick_g = ext_edge & ext_running(ext_mode_r); // RL12

    // internal divider: field 00 is /8 down to 11 is /1
    scs_tick_div u_int_div (
        .mclk(mclk),
        .srst(srst),
        .tick_in(int_tick_g),
        .ratio_log2(~int_div_r), // RL4 RL18
        .tick_out_r(int_div_tick)
    );

    // external halving stage for the divide-by-two modes
    scs_tick_div u_ext_div (
        .mclk(mclk),
        .srst(srst),
        .tick_in(ext_tick_g),
        .ratio_log2(ext_halved(ext_mode_r) ? SCS_LOG2_DIV2 : SCS_LOG2_DIV1), // RL12
        .tick_out_r(ext_div_tick)
    );

    // register writes and read data
    always_comb begin
        int_en_nxt = int_en_r;
        int_div_nxt = int_div_r;
        cal_nxt = cal_r;
        ext_mode_nxt = ext_mode_r;
        ext_freq_nxt = ext_freq_r;
        sel_nxt = sel_r;
        rdata_nxt = sfr_rdata_r;
        if (wr_hit) begin
            case (sfr_req.addr)
                SCS_ADDR_INT_CTRL: begin
                    // enable and divider in one write; ready and reserved ignored
                    int_en_nxt = sfr_req.wdata[SCS_INT_EN_BIT]; // RL5 RL10
                    int_div_nxt = sfr_req.wdata[SCS_INT_DIV_HI:SCS_INT_DIV_LO]; // RL4
                end
                SCS_ADDR_INT_CAL: begin
                    cal_nxt = sfr_req.wdata; // RL2
                end
                SCS_ADDR_EXT_CTRL: begin
                    // valid flag and bit three are not writable
                    ext_mode_nxt = sfr_req.wdata[SCS_EXT_MODE_HI:SCS_EXT_MODE_LO]; // RL12
                    ext_freq_nxt = sfr_req.wdata[SCS_EXT_FREQ_HI:SCS_EXT_FREQ_LO]; // RL13
                end
                SCS_ADDR_SRC_SEL: begin
                    sel_nxt = sfr_req.wdata[SCS_SEL_BIT]; // RL7 RL9
                end
                default: begin
                    // unmapped write is dropped
                end
            endcase
        end
        if (rd_hit) begin
            rdata_nxt = 8'h00;
            case (sfr_req.addr)
                SCS_ADDR_INT_CTRL: begin
                    rdata_nxt[SCS_INT_EN_BIT] = int_en_r; // RL5
                    rdata_nxt[SCS_INT_RDY_BIT] = int_rdy_r; // RL6
                    rdata_nxt[SCS_INT_DIV_HI:SCS_INT_DIV_LO] = int_div_r;
                end
                SCS_ADDR_INT_CAL: begin
                    rdata_nxt = cal_r;
                end
                SCS_ADDR_EXT_CTRL: begin
                    // bit three stays zero
                    rdata_nxt[SCS_EXT_VLD_BIT] = xtal_vld_r; // RL11 RL13
                    rdata_nxt[SCS_EXT_MODE_HI:SCS_EXT_MODE_LO] = ext_mode_r;
                    rdata_nxt[SCS_EXT_FREQ_HI:SCS_EXT_FREQ_LO] = ext_freq_r;
                end
                SCS_ADDR_SRC_SEL: begin
                    rdata_nxt[SCS_SEL_BIT] = sel_r; // RL7
                end
                default: begin
                    // unmapped read returns zero
                end
            endcase
        end
    end

    // register storage
    always_ff @(posedge mclk) begin
        if (srst) begin
            int_en_r <= SCS_INT_CTRL_RST[SCS_INT_EN_BIT]; // RL1
            int_div_r <= SCS_INT_DIV_RST;
            cal_r <= CAL_RESET; // RL2
            ext_mode_r <= SCS_EXT_MODE_RST;
            ext_freq_r <= SCS_EXT_FREQ_RST;
            sel_r <= SCS_SEL_RST; // RL1
            sfr_rdata_r <= 8'h00;
        end else begin
            int_en_r <= int_en_nxt;
            int_div_r <= int_div_nxt;
            cal_r <= cal_nxt;
            ext_mode_r <= ext_mode_nxt;
            ext_freq_r <= ext_freq_nxt;
            sel_r <= sel_nxt;
            sfr_rdata_r <= rdata_nxt;
        end
    end

    // ready and valid detection
    always_comb begin
        pin_d_nxt = crystal_pin_one;
        int_cnt_nxt = int_cnt_r;
        int_rdy_nxt = int_rdy_r;
        xtal_cnt_nxt = xtal_cnt_r;
        xtal_vld_nxt = xtal_vld_r;
        if (!int_en_nxt) begin
            // disabled oscillator is not at frequency
            int_cnt_nxt = 4'h0;
            int_rdy_nxt = 1'b0; // RL6
        end else if (int_tick_g && int_cnt_r != SCS_INTERNAL_FREQ_READY_TICKS) begin
            int_cnt_nxt = int_cnt_r + 4'h1;
            int_rdy_nxt = (int_cnt_r + 4'h1 == SCS_INTERNAL_FREQ_READY_TICKS); // RL6
        end
        if (mode_class(ext_mode_r) != SCS_XMODE_XTAL || !crystal_amp_ok) begin
            // unused or unstable crystal reads invalid
            xtal_cnt_nxt = 5'h00;
            xtal_vld_nxt = 1'b0; // RL11
        end else if (ext_edge && xtal_cnt_r != SCS_XTAL_EDGES) begin
            xtal_cnt_nxt = xtal_cnt_r + 5'h01;
            xtal_vld_nxt = (xtal_cnt_r + 5'h01 == SCS_XTAL_EDGES); // RL11
        end
    end

    // ready and valid registers; oscillator counts as settled at reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_d_r <= 1'b0;
            int_cnt_r <= SCS_INTERNAL_FREQ_READY_TICKS;
            int_rdy_r <= SCS_INT_CTRL_RST[SCS_INT_RDY_BIT];
            xtal_cnt_r <= 5'h00;
            xtal_vld_r <= 1'b0;
        end else begin
            pin_d_r <= pin_d_nxt;
            int_cnt_r <= int_cnt_nxt;
            int_rdy_r <= int_rdy_nxt;
            xtal_cnt_r <= xtal_cnt_nxt;
            xtal_vld_r <= xtal_vld_nxt;
        end
    end

    // source switch: the new source takes over on its own first tick,
    // the old one keeps running until then, so the last period before takeover can be as short as one cycle
    always_comb begin
        state_nxt = state_r;
        sysclk_nxt = 1'b0;
        case (state_r)
            SCS_ST_RUN_INT: begin
                sysclk_nxt = int_div_tick;
                if (sel_r) begin
                    state_nxt = SCS_ST_WAIT_EXT; // RL9
                end
            end
            SCS_ST_WAIT_EXT: begin
                if (!sel_r) begin
                    // request withdrawn before takeover
                    sysclk_nxt = int_div_tick;
                    state_nxt = SCS_ST_RUN_INT;
                end else if (ext_div_tick) begin
                    sysclk_nxt = 1'b1;
                    state_nxt = SCS_ST_RUN_EXT; // RL18
                end else begin
                    sysclk_nxt = int_div_tick;
                end
            end
            SCS_ST_RUN_EXT: begin
                sysclk_nxt = ext_div_tick;
                if (!sel_r) begin
                    state_nxt = SCS_ST_WAIT_INT; // RL9
                end
            end
            SCS_ST_WAIT_INT: begin
                if (sel_r) begin
                    sysclk_nxt = ext_div_tick;
                    state_nxt = SCS_ST_RUN_EXT;
                end else if (int_div_tick) begin
                    sysclk_nxt = 1'b1;
                    state_nxt = SCS_ST_RUN_INT; // RL18 RL10
                end else begin
                    sysclk_nxt = ext_div_tick;
                end
            end
            default: begin
                state_nxt = SCS_ST_RUN_INT;
            end
        endcase
        periph_nxt = ext_div_tick; // RL8
        is_ext_nxt = (state_nxt == SCS_ST_RUN_EXT) || (state_nxt == SCS_ST_WAIT_INT);
        analog_nxt.int_en = int_en_r; // RL5
        analog_nxt.int_trim = cal_r; // RL2
        analog_nxt.ext_mode = ext_mode_r; // RL12
        analog_nxt.ext_freq = ext_freq_r;
    end

    // switch state and outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= SCS_ST_RUN_INT; // RL1
            sysclk_en_r <= 1'b0;
            periph_ext_en_r <= 1'b0;
            sysclk_is_ext_r <= 1'b0;
            analog_r.int_en <= SCS_INT_CTRL_RST[SCS_INT_EN_BIT];
            analog_r.int_trim <= CAL_RESET;
            analog_r.ext_mode <= SCS_EXT_MODE_RST;
            analog_r.ext_freq <= SCS_EXT_FREQ_RST;
        end else begin
            state_r <= state_nxt;
            sysclk_en_r <= sysclk_nxt;
            periph_ext_en_r <= periph_nxt;
            sysclk_is_ext_r <= is_ext_nxt;
            analog_r <= analog_nxt;
        end
    end

endmodule : scs_clock_control

//--- verification/scs_clock_control_props.sv
// scs_clock_control_props: port-level assertions for the clock control block.
// assumes it is bound to scs_clock_control and sees only that module's ports.
`timescale 1ns/10ps
module scs_clock_control_props
    import scs_pkg::*;
#(
    parameter logic [7:0] CAL_RESET = SCS_CAL_RST
)
(
    input wire logic mclk,
    input wire logic srst,
    input scs_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata_r,
    input wire logic int_osc_tick,
    input wire logic crystal_pin_one,
    input wire logic crystal_amp_ok,
    input scs_analog_s analog_r,
    input wire logic sysclk_en_r,
    input wire logic periph_ext_en_r,
    input wire logic sysclk_is_ext_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // decoded bus strobes
    logic rd_ok, wr_ok, rd_map, wr_int, wr_cal, wr_ext, rd_ext, wen;
    logic [2:0] wmode; // mode field of the write data
    assign rd_ok = sfr_req.rd && sfr_req.page_ok;
    assign wr_ok = sfr_req.wr && sfr_req.page_ok;
    assign rd_map = sfr_req.addr inside {SCS_ADDR_INT_CTRL, SCS_ADDR_INT_CAL, SCS_ADDR_EXT_CTRL,
        SCS_ADDR_SRC_SEL};
    assign wr_int = wr_ok && sfr_req.addr == SCS_ADDR_INT_CTRL;
    assign wr_cal = wr_ok && sfr_req.addr == SCS_ADDR_INT_CAL;
    assign wr_ext = wr_ok && sfr_req.addr == SCS_ADDR_EXT_CTRL;
    assign rd_ext = rd_ok && sfr_req.addr == SCS_ADDR_EXT_CTRL;
    assign wen = sfr_req.wdata[SCS_INT_EN_BIT];
    assign wmode = sfr_req.wdata[SCS_EXT_MODE_HI:SCS_EXT_MODE_LO];

    a_reset_state: assert property ($past(srst) |-> !sysclk_en_r && !sysclk_is_ext_r
        && analog_r.int_en && analog_r.int_trim == CAL_RESET) else $error("bad reset state");
    a_rdata_holds: assert property (!rd_ok |=> $stable(sfr_rdata_r))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd_ok && !rd_map |=> sfr_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    a_int_reserved: assert property (rd_ok && sfr_req.addr == SCS_ADDR_INT_CTRL
        |=> sfr_rdata_r[5:2] == 4'h0) else $error("reserved bits set");
    a_sel_reserved: assert property (rd_ok && sfr_req.addr == SCS_ADDR_SRC_SEL
        |=> sfr_rdata_r[7:1] == 7'h00) else $error("select reserved bits set");
    a_bit3_zero: assert property (rd_ext |=> sfr_rdata_r[3] == 1'b0)
        else $error("ext bit three set");
    a_trim_follows: assert property (wr_cal ##1 !wr_cal
        |=> analog_r.int_trim == $past(sfr_req.wdata, 2)) else $error("trim not applied");
    a_enable_follows: assert property (wr_int ##1 !wr_int
        |=> analog_r.int_en == $past(wen, 2)) else $error("enable not applied");
    a_mode_follows: assert property (wr_ext ##1 !wr_ext
        |=> analog_r.ext_mode == $past(wmode, 2)) else $error("mode not applied");
    a_off_no_ticks: assert property ((analog_r.ext_mode[2:1] == SCS_XMODE_OFF) [*4]
        |-> !periph_ext_en_r) else $error("ext pulse while off");
    a_valid_xtal: assert property (rd_ext && !$past(wr_ext) ##1 sfr_rdata_r[7]
        |-> sfr_rdata_r[6:5] == 2'b11) else $error("valid outside crystal mode");
    a_switch_ext: assert property ($rose(sysclk_is_ext_r) |-> sysclk_en_r)
        else $error("switch to ext without pulse");
    a_switch_int: assert property ($fell(sysclk_is_ext_r) && !$past(srst)
        |-> sysclk_en_r) else $error("switch back without pulse");

    c_ext_run: cover property ($rose(sysclk_is_ext_r));
    c_valid: cover property (rd_ext ##1 sfr_rdata_r[7]);
    c_periph: cover property (periph_ext_en_r && !sysclk_is_ext_r);
endmodule : scs_clock_control_props

bind scs_clock_control scs_clock_control_props #(.CAL_RESET(CAL_RESET)) i_props (
    .mclk(mclk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata_r(sfr_rdata_r),
    .int_osc_tick(int_osc_tick), .crystal_pin_one(crystal_pin_one),
    .crystal_amp_ok(crystal_amp_ok), .analog_r(analog_r), .sysclk_en_r(sysclk_en_r),
    .periph_ext_en_r(periph_ext_en_r), .sysclk_is_ext_r(sysclk_is_ext_r));

//--- verification/scs_ext_osc_model.sv
// scs_ext_osc_model: external oscillator stand-in (crystal, rc or cmos clock).
// assumes the mode comes from the block's analog settings; changes at falling mclk.
`timescale 1ns/10ps
module scs_ext_osc_model
    import scs_pkg::*;
#(
    parameter int HALF = 3,
    parameter int SETTLE = 40
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [2:0] mode,
    input wire logic amp_fail,
    output logic pin,
    output logic amp_ok
);
    int half_cnt; // cycles into the current half period
    int run_cnt; // cycles of crystal drive so far
    // pin toggles while the drive is on and rests low when it is off
    always @(negedge mclk) begin
        if (srst || mode[2:1] == SCS_XMODE_OFF) begin
            pin <= 1'b0;
            half_cnt <= 0;
        end else if (half_cnt == HALF - 1) begin
            pin <= ~pin;
            half_cnt <= 0;
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end
    // amplitude needs a settle time after crystal drive starts
    always @(negedge mclk) begin
        if (srst || mode[2:1] != SCS_XMODE_XTAL) begin
            run_cnt <= 0;
        end else if (run_cnt < SETTLE) begin
            run_cnt <= run_cnt + 1;
        end
    end
    // a commanded fault drops the amplitude at once
    assign amp_ok = run_cnt == SETTLE && !amp_fail && mode[2:1] == SCS_XMODE_XTAL;
endmodule : scs_ext_osc_model

//--- verification/scs_clock_control_test.sv
// scs_clock_control_test: register-level tests of the clock control block.
// assumes an internal tick every second cycle and a 6-cycle external pin period.
`timescale 1ns/10ps
module scs_clock_control_test
    import scs_pkg::*;
;
    localparam logic [7:0] TRIM = 8'h5A; // stand-in trim, value arbitrary
    logic mclk, srst, int_osc_tick, amp_fail;
    scs_sfr_req_s req; // bus request
    logic [7:0] rdata;
    scs_analog_s ana;
    logic sys_en, per_en, is_ext, pin, amp_ok;
    int num_errors = 0, n_checks = 0, g, k;

    scs_clock_control #(.CAL_RESET(TRIM)) i_dut (.mclk(mclk), .srst(srst), .sfr_req(req),
        .sfr_rdata_r(rdata), .int_osc_tick(int_osc_tick), .crystal_pin_one(pin),
        .crystal_amp_ok(amp_ok), .analog_r(ana), .sysclk_en_r(sys_en),
        .periph_ext_en_r(per_en), .sysclk_is_ext_r(is_ext));
    scs_ext_osc_model #(.HALF(3), .SETTLE(40)) i_osc (.mclk(mclk), .srst(srst),
        .mode(ana.ext_mode), .amp_fail(amp_fail), .pin(pin), .amp_ok(amp_ok));

    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // internal oscillator stand-in: one tick every second cycle
    always @(negedge mclk) int_osc_tick <= (int_osc_tick !== 1'b1);

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one-cycle strobes, launched and dropped at falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, page_ok: 1'b1, wdata: d};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : wr

    task automatic rd_raw(input logic [7:0] a);
        @(negedge mclk);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, page_ok: 1'b1, wdata: 8'h00};
        @(negedge mclk);
        req.rd = 1'b0;
    endtask : rd_raw

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        rd_raw(a);
        chk(rdata & m, exp, "read data");
    endtask : rd

    // cycles between two pulses of sysclk (ext=0) or peripheral clock (ext=1); 0 if none
    task automatic gap(input logic ext, output int n);
        int w = 0;
        n = 0;
        while ((ext ? per_en : sys_en) !== 1'b1 && w < 64) begin
            @(negedge mclk);
            w++;
        end
        if (w == 64) return;
        do begin
            @(negedge mclk);
            n++;
        end while ((ext ? per_en : sys_en) !== 1'b1 && n < 64);
    endtask : gap

    task automatic wait_ext(input logic v);
        int w = 0;
        while (is_ext !== v && w < 300) begin
            @(negedge mclk);
            w++;
        end
        chk({7'h00, is_ext}, {7'h00, v}, "source flag");
    endtask : wait_ext

    // watchdog, well beyond the thousand or so cycles the tests need
    initial begin
        #100000;
        num_errors++;
        $display("FAIL %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        req = '0;
        srst = 1'b1;
        amp_fail = 1'b0;
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        rd(SCS_ADDR_INT_CTRL, 8'hC0, 8'hFF);
        rd(SCS_ADDR_INT_CAL, TRIM, 8'hFF);
        rd(SCS_ADDR_EXT_CTRL, 8'h00, 8'hFF);
        rd(SCS_ADDR_SRC_SEL, 8'h00, 8'hFF);
        gap(1'b0, g);
        chk(8'(g), 8'h10, "reset sysclk period");
        $display("test reset values done");
        wr(SCS_ADDR_INT_CAL, 8'h3C);
        rd(SCS_ADDR_INT_CAL, 8'h3C, 8'hFF);
        chk(ana.int_trim, 8'h3C, "trim output");
        @(negedge mclk);
        req = '{addr: SCS_ADDR_INT_CAL, wr: 1'b1, rd: 1'b0, page_ok: 1'b0, wdata: 8'h11};
        rd(SCS_ADDR_INT_CAL, 8'h3C, 8'hFF);
        rd(8'h90, 8'h00, 8'hFF);
        wr(SCS_ADDR_SRC_SEL, 8'hFE);
        rd(SCS_ADDR_SRC_SEL, 8'h00, 8'hFF);
        wr(SCS_ADDR_EXT_CTRL, 8'hFF);
        rd(SCS_ADDR_EXT_CTRL, 8'h77, 8'h7F);
        $display("test register access done");
        for (int c = 0; c < 4; c++) begin
            wr(SCS_ADDR_INT_CTRL, 8'h80 | 8'(c));
            gap(1'b0, g);
            gap(1'b0, g);
            chk(8'(g), 8'(2 * (8 >> c)), "divided period");
        end
        wr(SCS_ADDR_INT_CTRL, 8'h03);
        rd(SCS_ADDR_INT_CTRL, 8'h03, 8'hFF);
        gap(1'b0, g);
        chk(8'(g), 8'h00, "sysclk while disabled");
        wr(SCS_ADDR_INT_CTRL, 8'h83);
        rd(SCS_ADDR_INT_CTRL, 8'h83, 8'hFF);
        gap(1'b0, g);
        gap(1'b0, g);
        chk(8'(g), 8'h02, "enable and run");
        repeat (12) @(negedge mclk);
        rd(SCS_ADDR_INT_CTRL, 8'hC3, 8'hFF);
        wr(SCS_ADDR_INT_CTRL, 8'hBF);
        rd(SCS_ADDR_INT_CTRL, 8'h83, 8'hBF);
        $display("test internal oscillator done");
        for (int m = 0; m < 6; m++) begin
            wr(SCS_ADDR_EXT_CTRL, {1'b0, 3'(m), 4'h0});
            gap(1'b1, g);
            gap(1'b1, g);
            chk(8'(g), m < 2 ? 8'h00 : m == 2 ? 8'h06 : 8'h0C, "ext period");
        end
        chk({7'h00, is_ext}, 8'h00, "still internal");
        $display("test external modes done");
        wr(SCS_ADDR_EXT_CTRL, 8'h67);
        rd(SCS_ADDR_EXT_CTRL, 8'h67, 8'hFF);
        repeat (60) @(negedge mclk);
        k = 0;
        do begin
            rd_raw(SCS_ADDR_EXT_CTRL);
            k++;
        end while (rdata[7] !== 1'b1 && k < 100);
        chk(rdata, 8'hE7, "crystal valid");
        chk({5'h00, ana.ext_freq}, 8'h07, "freq output");
        wr(SCS_ADDR_SRC_SEL, 8'h01);
        wait_ext(1'b1);
        gap(1'b0, g);
        chk(8'(g), 8'h06, "sysclk from crystal");
        rd(SCS_ADDR_SRC_SEL, 8'h01, 8'hFF);
        amp_fail = 1'b1;
        repeat (4) @(negedge mclk);
        rd(SCS_ADDR_EXT_CTRL, 8'h67, 8'hFF);
        amp_fail = 1'b0;
        wr(SCS_ADDR_SRC_SEL, 8'h00);
        wait_ext(1'b0);
        gap(1'b0, g);
        chk(8'(g), 8'h02, "back to internal");
        wr(SCS_ADDR_SRC_SEL, 8'h01);
        wait_ext(1'b1);
        $display("test crystal switch done");
        @(negedge mclk);
        srst = 1'b1;
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        chk({7'h00, is_ext}, 8'h00, "source after reset");
        rd(SCS_ADDR_SRC_SEL, 8'h00, 8'hFF);
        rd(SCS_ADDR_INT_CTRL, 8'hC0, 8'hFF);
        rd(SCS_ADDR_EXT_CTRL, 8'h00, 8'hFF);
        gap(1'b0, g);
        chk(8'(g), 8'h10, "sysclk after reset");
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule : scs_clock_control_test
